// *** design/pwm_brake_ctrl.sv ***
// Top: AXI4-Lite registers, down counter, shadow transfer and brake source
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_brake_ctrl
   import pwm_brake_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic BRAKE_PIN,
   output logic [pwm_brake_pkg::NCH-1:0] PWM_OUT,
   input wire logic [pwm_brake_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [pwm_brake_pkg::DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [pwm_brake_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [pwm_brake_pkg::DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import pwm_brake_pkg::*;

   function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      if (a[1:0] != 2'h0 || a[ADDR_W-1:10] != '0) begin
         reg_sel = SEL_NONE;
      end else if (idx >= IDX_RELOAD_LO && idx <= IDX_CMP_HI) begin
         reg_sel = 4'(idx - IDX_RELOAD_LO);
      end else if (idx == IDX_CTRL) begin
         reg_sel = SEL_CTRL;
      end else if (idx == IDX_BRAKE) begin
         reg_sel = SEL_BRAKE;
      end else begin
         reg_sel = SEL_NONE;
      end
   endfunction

   // Bus state
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [7:0] rdata_q, rdata_d;
   // Block state
   logic [7:0] ctrl_q, ctrl_d, brk_q, brk_d;
   logic [7:0] shadow_q [NSHADOW];
   logic [7:0] shadow_d [NSHADOW];
   logic [CNT_W-1:0] count_q, count_d, reload_q, reload_d;
   logic [CNT_W-1:0] cmp_q [NCH];
   logic [CNT_W-1:0] cmp_d [NCH];
   // Combinational
   logic do_write, wr_en, rd_take, brake, pin_brake, pin_active, run_en, underflow, shadow_transfer_bit_now;
   logic [3:0] wsel, rsel;
   logic [NCH-1:0] inv;

   assign S_AXI_AWREADY = CE && !aw_hold_q;
   assign S_AXI_WREADY = CE && !w_hold_q;
   assign S_AXI_ARREADY = CE && !rvalid_q;
   assign S_AXI_BVALID = CE && bvalid_q;
   assign S_AXI_RVALID = CE && rvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RRESP = rresp_q;
   assign S_AXI_RDATA = {24'h000000, rdata_q};

   assign inv = {ctrl_q[INV_BIT3], ctrl_q[INV_BIT2], ctrl_q[INV_BIT1], ctrl_q[INV_BIT0]};
   assign pin_active = (BRAKE_PIN == brk_q[POL_BIT]);
   assign pin_brake = brk_q[BRK_EN_BIT] && brk_q[PIN_EN_BIT] && pin_active;
   always_comb begin
      // Enable gates every source
      brake = brk_q[BRK_EN_BIT] && (
         (!brk_q[HALT_SEL_BIT] && !brk_q[PIN_EN_BIT]) ||
         (brk_q[HALT_SEL_BIT] && !ctrl_q[RUN_BIT]) ||
         (brk_q[PIN_EN_BIT] && pin_active));
   end
   assign run_en = ctrl_q[RUN_BIT] && !brake;
   assign underflow = run_en && (count_q == CNT_RESET);
   assign shadow_transfer_bit_now = underflow && ctrl_q[SHADOW_TRANSFER_BIT_BIT];

   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (S_AXI_AWVALID && !aw_hold_q) begin
         aw_hold_d = 1'b1;
         awaddr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_hold_q) begin
         w_hold_d = 1'b1;
         wdata_d = S_AXI_WDATA[7:0];
         wstrb0_d = S_AXI_WSTRB[0];
      end
      if (bvalid_q && S_AXI_BREADY) begin
         bvalid_d = 1'b0;
      end
      do_write = aw_hold_q && w_hold_q && !bvalid_q;
      wsel = reg_sel(awaddr_q);
      wr_en = do_write && wsel != SEL_NONE && wstrb0_q;
      if (do_write) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid_q && S_AXI_RREADY) begin
         rvalid_d = 1'b0;
      end
      rd_take = S_AXI_ARVALID && !rvalid_q;
      rsel = reg_sel(S_AXI_ARADDR);
      if (rd_take) begin
         rvalid_d = 1'b1;
         rresp_d = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         if (rsel == SEL_CTRL) begin
            rdata_d = ctrl_q;
         end else if (rsel == SEL_BRAKE) begin
            rdata_d = brk_q;
         end else if (rsel < 4'(NSHADOW)) begin
            rdata_d = shadow_q[rsel[2:0]];
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_comb begin
      ctrl_d = ctrl_q;
      brk_d = brk_q;
      shadow_d = shadow_q;
      reload_d = reload_q;
      cmp_d = cmp_q;
      count_d = count_q;
      if (shadow_transfer_bit_now) begin
         // Only path from shadow to active
         reload_d = {shadow_q[1][1:0], shadow_q[0]};
         for (int n = 0; n < NCH; n++) begin
            cmp_d[n] = {shadow_q[6][2*n+1 -: 2], shadow_q[2+n]};
         end
         ctrl_d[SHADOW_TRANSFER_BIT_BIT] = 1'b0;
      end
      if (pin_brake) begin
         ctrl_d[RUN_BIT] = 1'b0;
      end
      if (run_en) begin
         count_d = underflow ? reload_d : count_q - 10'h001;
      end
      // Software write wins over hardware clears
      if (wr_en) begin
         if (wsel == SEL_CTRL) begin
            ctrl_d = wdata_q & CTRL_WMASK;
         end else if (wsel == SEL_BRAKE) begin
            brk_d = wdata_q;
         end else begin
            shadow_d[wsel[2:0]] = wdata_q;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 8'h00;
         ctrl_q <= CTRL_RESET;
         brk_q <= BRAKE_RESET;
         shadow_q <= '{default: SHADOW_RESET};
         reload_q <= CNT_RESET;
         cmp_q <= '{default: CNT_RESET};
         count_q <= CNT_RESET;
      end else if (CE) begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         brk_q <= brk_d;
         shadow_q <= shadow_d;
         reload_q <= reload_d;
         cmp_q <= cmp_d;
         count_q <= count_d;
      end
   end

   for (genvar n = 0; n < NCH; n++) begin : g_ch
      pwm_channel u_ch (
         .clk(REF_CLK),
         .srst(SRST),
         .ce(CE),
         .tick(run_en),
         .cnt(count_d),
         .cmp(cmp_d[n]),
         .reload(reload_d),
         .inv(inv[n]),
         .brake(brake),
         .level(brk_q[n]),
         .out(PWM_OUT[n])
      );
   end

   property p_no_enable;
      @(posedge REF_CLK) disable iff (SRST) !brk_q[BRK_EN_BIT] |-> !brake;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("brake without enable");

   property p_always_on;
      @(posedge REF_CLK) disable iff (SRST)
         brk_q[BRK_EN_BIT] && !brk_q[HALT_SEL_BIT] && !brk_q[PIN_EN_BIT] |-> brake;
   endproperty
   a_always_on: assert property (p_always_on) else $error("software brake missing");

   property p_halt_brake;
      @(posedge REF_CLK) disable iff (SRST)
         brk_q[BRK_EN_BIT] && brk_q[HALT_SEL_BIT] && !brk_q[PIN_EN_BIT]
         |-> brake == !ctrl_q[RUN_BIT];
   endproperty
   a_halt_brake: assert property (p_halt_brake) else $error("halt brake wrong");

   property p_pin_brake;
      @(posedge REF_CLK) disable iff (SRST)
         brk_q[BRK_EN_BIT] && brk_q[PIN_EN_BIT] && !brk_q[HALT_SEL_BIT]
         |-> brake == (BRAKE_PIN == brk_q[POL_BIT]);
   endproperty
   a_pin_brake: assert property (p_pin_brake) else $error("pin brake wrong");

   property p_run_cleared;
      @(posedge REF_CLK) disable iff (SRST) CE && pin_brake && !wr_en |=> !ctrl_q[RUN_BIT];
   endproperty
   a_run_cleared: assert property (p_run_cleared) else $error("run not cleared");

   sequence s_transfer;
      CE && shadow_transfer_bit_now && !wr_en;
   endsequence
   property p_transfer;
      @(posedge REF_CLK) disable iff (SRST)
         s_transfer |=> !ctrl_q[SHADOW_TRANSFER_BIT_BIT] && cmp_q[0] == {$past(shadow_q[6][1:0]), $past(shadow_q[2])}
         && count_q == reload_q;
   endproperty
   a_transfer: assert property (p_transfer) else $error("transfer failed");

   property p_isolated;
      @(posedge REF_CLK) disable iff (SRST) !(CE && shadow_transfer_bit_now) |=> $stable(reload_q) && $stable(cmp_q[3]);
   endproperty
   a_isolated: assert property (p_isolated) else $error("shadow leaked");

   property p_halt_count;
      @(posedge REF_CLK) disable iff (SRST) !ctrl_q[RUN_BIT] ##1 !ctrl_q[RUN_BIT] |-> $stable(count_q);
   endproperty
   a_halt_count: assert property (p_halt_count) else $error("counter ran while halted");
endmodule
`default_nettype wire

// *** design/pwm_brake_pkg.sv ***
// Constants for the four-channel PWM run, transfer, inversion and brake block
package pwm_brake_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W = 10;
   localparam int unsigned NCH = 4;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_RELOAD_LO = 8'hD1;
   localparam logic [7:0] IDX_RELOAD_HI = 8'hD2;
   localparam logic [7:0] IDX_CMP0 = 8'hD3;
   localparam logic [7:0] IDX_CMP_HI = 8'hD7;
   localparam logic [7:0] IDX_CTRL = 8'hDA;
   localparam logic [7:0] IDX_BRAKE = 8'hDB;
   localparam int unsigned NSHADOW = 7;
   localparam logic [3:0] SEL_CTRL = 4'h7;
   localparam logic [3:0] SEL_BRAKE = 4'h8;
   localparam logic [3:0] SEL_NONE = 4'hF;
   // Control register fields
   localparam int unsigned RUN_BIT = 7;
   localparam int unsigned SHADOW_TRANSFER_BIT_BIT = 6;
   localparam int unsigned INV_BIT0 = 1;
   localparam int unsigned INV_BIT1 = 2;
   localparam int unsigned INV_BIT2 = 4;
   localparam int unsigned INV_BIT3 = 5;
   localparam logic [7:0] CTRL_WMASK = 8'hF6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Brake register fields
   localparam int unsigned HALT_SEL_BIT = 7;
   localparam int unsigned POL_BIT = 6;
   localparam int unsigned PIN_EN_BIT = 5;
   localparam int unsigned BRK_EN_BIT = 4;
   localparam logic [7:0] BRAKE_RESET = 8'h00;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   // Compare codes with fixed meaning
   localparam logic [CNT_W-1:0] CMP_ALL_LOW = 10'h3FF;
   localparam logic [CNT_W-1:0] CMP_ALL_HIGH = 10'h000;
   localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** design/pwm_channel.sv ***
// One PWM channel: waveform state, inversion and brake override
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
   import pwm_brake_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic tick,
   input wire logic [CNT_W-1:0] cnt,
   input wire logic [CNT_W-1:0] cmp,
   input wire logic [CNT_W-1:0] reload,
   input wire logic inv,
   input wire logic brake,
   input wire logic level,
   output logic out
);
   logic wave_q, wave_d, out_q, out_d, raw;

   always_comb begin
      // High from reload down to the compare value
      if (cmp == CMP_ALL_LOW) begin
         raw = 1'b0;
      end else begin
         raw = (cmp == CMP_ALL_HIGH) || (cmp > reload) || (cnt >= cmp);
      end
      wave_d = tick ? raw : wave_q;
      out_d = brake ? level : (wave_d ^ inv);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wave_q <= 1'b1;
         out_q <= 1'b1;
      end else if (ce) begin
         wave_q <= wave_d;
         out_q <= out_d;
      end
   end

   assign out = out_q;

   property p_brake_level;
      @(posedge clk) disable iff (srst) ce && brake |=> out == $past(level);
   endproperty
   a_brake_level: assert property (p_brake_level) else $error("brake level not forced");

   property p_halt_hold;
      @(posedge clk) disable iff (srst) ce && !tick |=> wave_q == $past(wave_q);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("waveform moved while halted");

   property p_polarity;
      @(posedge clk) disable iff (srst) ce && !brake |=> out == (wave_q ^ $past(inv));
   endproperty
   a_polarity: assert property (p_polarity) else $error("inversion wrong");

   sequence s_brake_then_release;
      ce && brake && !tick ##1 ce && !brake && !tick;
   endsequence
   property p_return;
      @(posedge clk) disable iff (srst) s_brake_then_release |=> out == (wave_q ^ $past(inv));
   endproperty
   a_return: assert property (p_return) else $error("no return to prior level");
endmodule
`default_nettype wire

// *** verif/brake_pin_model.sv ***
// Model of the external brake pin driven beside the PWM block
`timescale 1ns/1ps
`default_nettype none
module brake_pin_model (
   input wire logic clk,
   input wire logic level_req,
   output logic pin
);
   initial pin = 1'b0;
   // Pin level changes just after an edge; each level is held many cycles
   always @(posedge clk) begin
      pin <= level_req;
   end
endmodule
`default_nettype wire

// *** verif/pwm_run_transfer_brake_control_test.sv ***
// Self-checking testbench for the PWM run, transfer and brake block
`timescale 1ns/1ps
`default_nettype none
module pwm_run_transfer_brake_control_test;
   import pwm_brake_pkg::*;
   localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
   localparam logic [11:0] A_BRK = {2'b00, IDX_BRAKE, 2'b00};
   localparam logic [11:0] A_RLO = {2'b00, IDX_RELOAD_LO, 2'b00};
   localparam logic [11:0] A_CMP = {2'b00, IDX_CMP0, 2'b00};
   localparam logic [11:0] A_CHI = {2'b00, IDX_CMP_HI, 2'b00};
   localparam int NROW = 6;
   logic ref_clk, srst, ce, pin_req, brake_pin;
   logic [3:0] pwm_out;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_v;
   logic [1:0] bresp, rresp, rs;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   int miscompares, tests_run, cycles;
   logic [31:0] h [4];
   logic [31:0] inv_ok;
   logic [11:0] r_a [NROW] = '{A_CTRL, A_BRK, 12'h000, 12'h369, A_CTRL, A_BRK};
   logic [7:0] r_w [NROW] = '{8'h3F, 8'h0F, 8'h55, 8'h55, 8'h00, 8'h00};
   logic [31:0] r_r [NROW] = '{32'h36, 32'h0F, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [1:0] r_s [NROW] = '{RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_SLVERR,
      RESP_OKAY, RESP_OKAY};

   pwm_brake_ctrl dut (.REF_CLK(ref_clk), .SRST(srst), .CE(ce), .BRAKE_PIN(brake_pin),
      .PWM_OUT(pwm_out), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   brake_pin_model pin_src (.clk(ref_clk), .level_req(pin_req), .pin(brake_pin));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic finish_test;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      tb = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!tb) begin
         @(negedge ref_clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         rs = bresp;
         @(posedge ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
      end
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [11:0] a);
      logic ta, tr;
      tr = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!tr) begin
         @(negedge ref_clk);
         ta = arvalid & arready;
         tr = rvalid;
         rd_v = rdata;
         rs = rresp;
         @(posedge ref_clk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
      end
      @(posedge ref_clk);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      rd(a);
      chk(rd_v, {24'h0, e});
   endtask

   task automatic outc(input logic [3:0] e);
      repeat (5) @(negedge ref_clk);
      chk({28'h0, pwm_out}, {28'h0, e});
      @(posedge ref_clk);
   endtask

   task automatic wait_shadow_transfer_bit;
      int n;
      n = 0;
      rd(A_CTRL);
      while (rd_v[SHADOW_TRANSFER_BIT_BIT] !== 1'b0 && n < 50) begin
         rd(A_CTRL);
         n++;
      end
      chk({31'h0, rd_v[SHADOW_TRANSFER_BIT_BIT]}, 32'h0);
   endtask

   task automatic meas;
      h = '{0, 0, 0, 0};
      inv_ok = 0;
      repeat (8) begin
         @(negedge ref_clk);
         // Four-state sums so an unknown output cannot pass as zero
         for (int i = 0; i < 4; i++)
            h[i] += 32'(pwm_out[i]);
         inv_ok += 32'(pwm_out[3] ^ pwm_out[0]);
      end
      @(posedge ref_clk);
   endtask

   // Brake select bits are never both set; pin level goes first
   task automatic bstep(input logic [7:0] bk, input logic p, input logic [3:0] e);
      pin_req <= p;
      wr(A_BRK, bk);
      outc(e);
   endtask

   initial begin
      {srst, ce, pin_req, awvalid, wvalid, bready, arvalid, rready} = 8'hC0;
      {awaddr, araddr, wdata} = '0;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      outc(4'hF);
      rdc(A_CTRL, CTRL_RESET);
      rdc(A_BRK, BRAKE_RESET);
      for (int i = 0; i < NROW; i++) begin
         wr(r_a[i], r_w[i]);
         chk({30'h0, rs}, {30'h0, r_s[i]});
         rd(r_a[i]);
         chk(rd_v, r_r[i]);
         chk({30'h0, rs}, {30'h0, r_s[i]});
      end
      // Reload 3; compares 2, always high, always low, 2 inverted
      wr(A_RLO, 8'h03);
      wr(A_RLO + 12'h4, 8'h00);
      wr(A_CMP, 8'h02);
      wr(A_CMP + 12'h4, 8'h00);
      wr(A_CMP + 12'h8, 8'hFF);
      wr(A_CMP + 12'hC, 8'h02);
      wr(A_CHI, 8'h30);
      wr(A_CTRL, 8'hE0);
      wait_shadow_transfer_bit();
      meas();
      chk(h[0], 4);
      chk(h[1], 8);
      chk(h[2], 0);
      chk(h[3], 4);
      chk(inv_ok, 8);
      wr(A_CMP, 8'h00);
      meas();
      chk(h[0], 4);
      for (int i = 0; i < 4; i++)
         wr(A_CMP + 12'(4 * i), 8'h00);
      wr(A_CHI, 8'h00);
      wr(A_CTRL, 8'hE0);
      wait_shadow_transfer_bit();
      repeat (8) @(posedge ref_clk);
      wr(A_CTRL, 8'h20);
      outc(4'h7);
      meas();
      chk(h[0] + h[1] + h[2] + h[3], 24);
      chk(inv_ok, 8);
      bstep(8'h1A, 1'b0, 4'hA);
      bstep(8'h0A, 1'b0, 4'h7);
      bstep(8'h6A, 1'b1, 4'h7);
      bstep(8'h8A, 1'b1, 4'h7);
      bstep(8'h9A, 1'b1, 4'hA);
      wr(A_CTRL, 8'hA0);
      outc(4'h7);
      bstep(8'h7A, 1'b0, 4'h7);
      rdc(A_CTRL, 8'hA0);
      bstep(8'h7A, 1'b1, 4'hA);
      rdc(A_CTRL, 8'h20);
      bstep(8'h7A, 1'b0, 4'h7);
      bstep(8'h3A, 1'b1, 4'h7);
      wr(A_CTRL, 8'hA0);
      outc(4'h7);
      bstep(8'h3A, 1'b0, 4'hA);
      rdc(A_CTRL, 8'h20);
      // Resume from pin brake through software brake
      wr(A_BRK, 8'h1A);
      outc(4'hA);
      wr(A_CTRL, 8'hE0);
      pin_req <= 1'b1;
      outc(4'hA);
      rdc(A_CTRL, 8'hE0);
      wr(A_BRK, 8'h0A);
      wait_shadow_transfer_bit();
      outc(4'h7);
      // Clock enable low gates the bus handshakes
      ce <= 1'b0;
      repeat (3) @(negedge ref_clk);
      chk({30'h0, awready, arready}, 32'h0);
      chk({28'h0, pwm_out}, 32'h7);
      @(posedge ref_clk);
      ce <= 1'b1;
      // Reset in mid-run
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      outc(4'hF);
      rdc(A_CTRL, CTRL_RESET);
      rdc(A_BRK, BRAKE_RESET);
      finish_test();
   end
endmodule
`default_nettype wire
